//--- inc/srlc_defines.svh
// Register map, field positions, reset values and timing counts of the set-reset latch
// Behaviour
// [R01] Latch enable off disables latch and pins
// [R02] True output enable drives latch state out
// [R03] Complement output enable drives inverted state out
// [R04] Both pins may be driven together
// [R05] Software clears pin direction bits externally
// [R06] Latch state never forced by reset
// [R07] Divider code gives pulse every 4..512 cycles
// [R08] Divider field sits in control bits 6:4
// [R09] Writing soft set gives one-cycle set
// [R10] Writing soft reset gives one-cycle reset
// [R11] Soft pulse bits always read zero
// [R12] Pin set enable lets pin set
// [R13] Clock set enable lets generator set
// [R14] Comparator two set enable lets it set
// [R15] Comparator one set enable lets it set
// [R16] Pin reset enable lets pin reset
// [R17] Clock reset enable lets generator reset
// [R18] Comparator two reset enable lets it reset
// [R19] Comparator one reset enable lets it reset
// [R20] Reset wins when set and reset both high
// [R21] All sources active high, no clocking needed; here sources and latch are sampled on core_clk_i each cycle
// [R22] Comparator inputs are the synchronised outputs
// [R23] Set and reset are ORs of enabled sources
// [R24] Free-running divider, new code at wrap
`ifndef SRLC_DEFINES_SVH
`define SRLC_DEFINES_SVH

`define SRLC_OFF_CONTROL 8'h00
`define SRLC_OFF_SOURCE 8'h04
`define SRLC_OFF_STATUS 8'h08

`define SRLC_CTL_LATCH_EN 7
`define SRLC_CTL_DIV_HI 6
`define SRLC_CTL_DIV_LO 4
`define SRLC_CTL_TRUE_EN 3
`define SRLC_CTL_COMP_EN 2
`define SRLC_CTL_SOFT_SET 1
`define SRLC_CTL_SOFT_RST 0

`define SRLC_SRC_PIN_SET 7
`define SRLC_SRC_CLK_SET 6
`define SRLC_SRC_CMP2_SET 5
`define SRLC_SRC_CMP1_SET 4
`define SRLC_SRC_PIN_RST 3
`define SRLC_SRC_CLK_RST 2
`define SRLC_SRC_CMP2_RST 1
`define SRLC_SRC_CMP1_RST 0

`define SRLC_STS_LATCH 0
`define SRLC_STS_PULSE 1

`define SRLC_CONTROL_RESET 8'h00
`define SRLC_SOURCE_RESET 8'h00

`define SRLC_DIV_BASE 10'h004
`define SRLC_CNT_W 10

`endif

//--- inc/srlc_pkg.sv
// Types shared by the set-reset latch design
package srlc_pkg;
  typedef logic [7:0] srlc_reg_t;
  typedef logic [2:0] srlc_div_t;
  typedef logic [9:0] srlc_cnt_t;
endpackage

//--- rtl/srlc_top.sv
// Set-reset latch with source selection, pulse generator and Wishbone register slave
//
// Our own choices: the Wishbone register port and the register addresses.
`include "srlc_defines.svh"

module srlc_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic latch_external_input_i,
  input wire logic cmp1_synced_output_i,
  input wire logic cmp2_synced_output_i,
  output logic latch_true_pin_o,
  output logic latch_true_pin_oe_o,
  output logic latch_complement_pin_o,
  output logic latch_complement_pin_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Last count of a period: 4 shifted by the code, minus one
  function automatic srlc_pkg::srlc_cnt_t last_count(input srlc_pkg::srlc_div_t code);
    srlc_pkg::srlc_cnt_t period;
    period = `SRLC_DIV_BASE << code;
    last_count = period - 10'h001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  srlc_pkg::srlc_reg_t control_q;
  srlc_pkg::srlc_reg_t source_q;
  logic soft_set_q;
  logic soft_rst_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic wr_ctl;
  logic wr_src;
  logic access;
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  srlc_pkg::srlc_cnt_t cnt_q;
  srlc_pkg::srlc_div_t active_div_q;
  logic pulse_q;
  logic wrap;
  logic set_in;
  logic rst_in;
  logic latch_q;
  logic ext_s;
  logic cmp1_s;
  logic cmp2_s;
  logic true_q;
  logic true_oe_q;
  logic comp_q;
  logic comp_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state, unmapped reads give zero

  assign access = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_ctl = access && wb_we_i && wb_sel_i[0] && (wb_adr_i == `SRLC_OFF_CONTROL);
  assign wr_src = access && wb_we_i && wb_sel_i[0] && (wb_adr_i == `SRLC_OFF_SOURCE);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h00000000;
    end else if (access && !wb_we_i) begin
      if (wb_adr_i == `SRLC_OFF_CONTROL) begin
        // Pulse bits are not stored, so they read back zero
        rdata_q <= {24'h000000, control_q[7:2], 2'h0}; // see [R11]
      end else if (wb_adr_i == `SRLC_OFF_SOURCE) begin
        rdata_q <= {24'h000000, source_q};
      end else if (wb_adr_i == `SRLC_OFF_STATUS) begin
        rdata_q <= {30'h00000000, pulse_q, latch_q};
      end else begin
        rdata_q <= 32'h00000000;
      end
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      control_q <= `SRLC_CONTROL_RESET;
    end else if (wr_ctl) begin
      // Divider code lands in bits 6:4 with the enables; pulse bits not kept
      control_q <= {wb_dat_i[7:2], 2'h0}; // see [R08]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      source_q <= `SRLC_SOURCE_RESET;
    end else if (wr_src) begin
      source_q <= wb_dat_i[7:0];
    end
  end

  // Writing one gives a single-cycle pulse; writing zero does nothing
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      soft_set_q <= 1'b0;
      soft_rst_q <= 1'b0;
    end else begin
      soft_set_q <= wr_ctl && wb_dat_i[`SRLC_CTL_SOFT_SET]; // see [R09]
      soft_rst_q <= wr_ctl && wb_dat_i[`SRLC_CTL_SOFT_RST]; // see [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; comparator signals come from the timer clock

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else begin
      pin_meta_q <= {cmp2_synced_output_i, cmp1_synced_output_i, latch_external_input_i}; // see [R22]
      pin_sync_q <= pin_meta_q;
    end
  end

  assign ext_s = pin_sync_q[0];
  assign cmp1_s = pin_sync_q[1];
  assign cmp2_s = pin_sync_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Pulse generator

  assign wrap = (cnt_q == last_count(active_div_q));

  // Free-running; a new code is taken only at wrap to avoid short periods
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_q <= 10'h000;
      active_div_q <= 3'h0;
    end else if (wrap) begin
      cnt_q <= 10'h000;
      active_div_q <= control_q[`SRLC_CTL_DIV_HI:`SRLC_CTL_DIV_LO]; // see [R24]
    end else begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= wrap; // see [R07]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection and latch

  // All sources active high, ORed after their enables
  always_comb begin
    set_in = soft_set_q; // see [R21]
    set_in = set_in || (source_q[`SRLC_SRC_PIN_SET] && ext_s); // see [R12]
    set_in = set_in || (source_q[`SRLC_SRC_CLK_SET] && pulse_q); // see [R13]
    set_in = set_in || (source_q[`SRLC_SRC_CMP2_SET] && cmp2_s); // see [R14]
    set_in = set_in || (source_q[`SRLC_SRC_CMP1_SET] && cmp1_s); // see [R15] [R23]
    rst_in = soft_rst_q;
    rst_in = rst_in || (source_q[`SRLC_SRC_PIN_RST] && ext_s); // see [R16]
    rst_in = rst_in || (source_q[`SRLC_SRC_CLK_RST] && pulse_q); // see [R17]
    rst_in = rst_in || (source_q[`SRLC_SRC_CMP2_RST] && cmp2_s); // see [R18]
    rst_in = rst_in || (source_q[`SRLC_SRC_CMP1_RST] && cmp1_s); // see [R19] [R23]
  end

  // Deliberately no reset term: state is unknown until software sets it
  // Sampled each cycle; a true clockless latch is not allowed in this flow
  always_ff @(posedge core_clk_i) begin
    if (control_q[`SRLC_CTL_LATCH_EN]) begin // see [R01] [R06]
      if (rst_in) begin
        latch_q <= 1'b0; // see [R20]
      end else if (set_in) begin
        latch_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers; the direction bit lives in the port block outside

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      true_q <= 1'b0;
      true_oe_q <= 1'b0;
    end else begin
      true_oe_q <= control_q[`SRLC_CTL_LATCH_EN] && control_q[`SRLC_CTL_TRUE_EN]; // see [R01] [R02]
      true_q <= control_q[`SRLC_CTL_LATCH_EN] && control_q[`SRLC_CTL_TRUE_EN] && latch_q; // see [R02]
    end
  end

  // Independent of the true pin, so both may drive together
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      comp_q <= 1'b0;
      comp_oe_q <= 1'b0;
    end else begin
      comp_oe_q <= control_q[`SRLC_CTL_LATCH_EN] && control_q[`SRLC_CTL_COMP_EN]; // see [R01] [R03] [R04]
      comp_q <= control_q[`SRLC_CTL_LATCH_EN] && control_q[`SRLC_CTL_COMP_EN] && !latch_q; // see [R03]
    end
  end

  assign latch_true_pin_o = true_q;
  assign latch_true_pin_oe_o = true_oe_q;
  assign latch_complement_pin_o = comp_q;
  assign latch_complement_pin_oe_o = comp_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  srlc_pkg::srlc_cnt_t gap_q;
  srlc_pkg::srlc_cnt_t expect_q;
  logic seen_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gap_q <= 10'h000;
      expect_q <= 10'h000;
      seen_q <= 1'b0;
    end else begin
      gap_q <= pulse_q ? 10'h001 : gap_q + 10'h001;
      if (wrap) begin
        expect_q <= last_count(active_div_q) + 10'h001;
      end
      if (pulse_q) begin
        seen_q <= 1'b1;
      end
    end
  end

  a_disabled_pins_off: assert property ( // see [R01]
    @(posedge core_clk_i) disable iff (rst_i)
    !control_q[`SRLC_CTL_LATCH_EN] |=> !latch_true_pin_oe_o && !latch_complement_pin_oe_o &&
      !latch_true_pin_o && !latch_complement_pin_o)
    else $error("pins driven while latch disabled");

  a_true_pin_drive: assert property ( // see [R02]
    @(posedge core_clk_i) disable iff (rst_i)
    control_q[`SRLC_CTL_LATCH_EN] && control_q[`SRLC_CTL_TRUE_EN] |=>
      latch_true_pin_oe_o && (latch_true_pin_o == $past(latch_q)))
    else $error("true pin does not follow latch");

  a_comp_pin_drive: assert property ( // see [R03]
    @(posedge core_clk_i) disable iff (rst_i)
    control_q[`SRLC_CTL_LATCH_EN] && control_q[`SRLC_CTL_COMP_EN] |=>
      latch_complement_pin_oe_o && (latch_complement_pin_o != $past(latch_q)))
    else $error("complement pin does not follow inverted latch");

  a_both_pins_drive: assert property ( // see [R04]
    @(posedge core_clk_i) disable iff (rst_i)
    control_q[`SRLC_CTL_LATCH_EN] && control_q[`SRLC_CTL_TRUE_EN] && control_q[`SRLC_CTL_COMP_EN] |=>
      latch_true_pin_oe_o && latch_complement_pin_oe_o && (latch_true_pin_o != latch_complement_pin_o))
    else $error("both pins not driven together");

  a_pulse_period: assert property ( // see [R07]
    @(posedge core_clk_i) disable iff (rst_i)
    pulse_q && seen_q |-> gap_q == expect_q)
    else $error("pulse spacing wrong for divider code");

  a_pulse_single: assert property ( // see [R07]
    @(posedge core_clk_i) disable iff (rst_i)
    pulse_q |=> !pulse_q [*3])
    else $error("pulses closer than four cycles");

  a_soft_set_pulse: assert property ( // see [R09]
    @(posedge core_clk_i) disable iff (rst_i)
    wr_ctl && wb_dat_i[`SRLC_CTL_SOFT_SET] |=> soft_set_q ##1 !soft_set_q)
    else $error("soft set not a one-cycle pulse");

  a_soft_rst_pulse: assert property ( // see [R10]
    @(posedge core_clk_i) disable iff (rst_i)
    wr_ctl && wb_dat_i[`SRLC_CTL_SOFT_RST] |=> soft_rst_q ##1 !soft_rst_q)
    else $error("soft reset not a one-cycle pulse");

  a_soft_bits_zero: assert property ( // see [R11]
    @(posedge core_clk_i) disable iff (rst_i)
    access && !wb_we_i && (wb_adr_i == `SRLC_OFF_CONTROL) |=> wb_ack_o && (wb_dat_o[1:0] == 2'h0))
    else $error("soft pulse bits read nonzero");

  a_reset_dominant: assert property ( // see [R20]
    @(posedge core_clk_i) disable iff (rst_i)
    control_q[`SRLC_CTL_LATCH_EN] && rst_in |=> !latch_q)
    else $error("latch not reset while reset input high");

  a_set_sources: assert property ( // see [R23]
    @(posedge core_clk_i) disable iff (rst_i)
    control_q[`SRLC_CTL_LATCH_EN] && set_in && !rst_in |=> latch_q)
    else $error("latch not set by enabled source");

  a_div_at_wrap: assert property ( // see [R24]
    @(posedge core_clk_i) disable iff (rst_i)
    !$past(wrap) |-> $stable(active_div_q))
    else $error("divider code changed away from wrap");

  a_sync_two_flops: assert property ( // see [R22]
    @(posedge core_clk_i) disable iff (rst_i)
    pin_sync_q == $past({cmp2_synced_output_i, cmp1_synced_output_i, latch_external_input_i}, 2))
    else $error("inputs not passed through two flip-flops");

  a_soft_set_zero: assert property ( // see [R09]
    @(posedge core_clk_i) disable iff (rst_i)
    wr_ctl && !wb_dat_i[`SRLC_CTL_SOFT_SET] |=> !soft_set_q)
    else $error("soft set pulsed by a zero write");

  a_soft_rst_zero: assert property ( // see [R10]
    @(posedge core_clk_i) disable iff (rst_i)
    wr_ctl && !wb_dat_i[`SRLC_CTL_SOFT_RST] |=> !soft_rst_q)
    else $error("soft reset pulsed by a zero write");

  a_cnt_in_period: assert property ( // see [R24]
    @(posedge core_clk_i) disable iff (rst_i)
    cnt_q <= last_count(active_div_q))
    else $error("divider count outside the selected period");

  a_div_field_write: assert property ( // see [R08]
    @(posedge core_clk_i) disable iff (rst_i)
    wr_ctl |=> control_q[`SRLC_CTL_DIV_HI:`SRLC_CTL_DIV_LO] == $past(wb_dat_i[`SRLC_CTL_DIV_HI:`SRLC_CTL_DIV_LO]))
    else $error("divider field not taken from the write");

  a_pin_sets: assert property ( // see [R12]
    @(posedge core_clk_i) disable iff (rst_i)
    control_q[`SRLC_CTL_LATCH_EN] && source_q[`SRLC_SRC_PIN_SET] && ext_s && !rst_in |=> latch_q)
    else $error("enabled pin did not set the latch");

  a_clk_sets: assert property ( // see [R13]
    @(posedge core_clk_i) disable iff (rst_i)
    control_q[`SRLC_CTL_LATCH_EN] && source_q[`SRLC_SRC_CLK_SET] && pulse_q && !rst_in |=> latch_q)
    else $error("enabled generator did not set the latch");

  a_cmp2_sets: assert property ( // see [R14]
    @(posedge core_clk_i) disable iff (rst_i)
    control_q[`SRLC_CTL_LATCH_EN] && source_q[`SRLC_SRC_CMP2_SET] && cmp2_s && !rst_in |=> latch_q)
    else $error("enabled comparator two did not set the latch");

  a_pin_resets: assert property ( // see [R16]
    @(posedge core_clk_i) disable iff (rst_i)
    control_q[`SRLC_CTL_LATCH_EN] && source_q[`SRLC_SRC_PIN_RST] && ext_s |=> !latch_q)
    else $error("enabled pin did not reset the latch");

  a_clk_resets: assert property ( // see [R17]
    @(posedge core_clk_i) disable iff (rst_i)
    control_q[`SRLC_CTL_LATCH_EN] && source_q[`SRLC_SRC_CLK_RST] && pulse_q |=> !latch_q)
    else $error("enabled generator did not reset the latch");

  a_cmp1_resets: assert property ( // see [R19]
    @(posedge core_clk_i) disable iff (rst_i)
    control_q[`SRLC_CTL_LATCH_EN] && source_q[`SRLC_SRC_CMP1_RST] && cmp1_s |=> !latch_q)
    else $error("enabled comparator one did not reset the latch");

endmodule // srlc_top

//--- verification/tb_srlc_top.sv
// Self-checking bench for the set-reset latch block
module tb_srlc_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk_i;
  logic rst_i;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w;
  logic [31:0] dat_r;
  logic ack;
  logic ext_in;
  logic cmp1;
  logic cmp2;
  logic tq;
  logic tq_oe;
  logic cq;
  logic cq_oe;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] v;
  logic init;
  int mismatches;
  int n_compared;
  int cycles;
  int n;

  srlc_top i_srlc_top (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(dat_w),
    .wb_dat_o(dat_r),
    .wb_ack_o(ack),
    .latch_external_input_i(ext_in),
    .cmp1_synced_output_i(cmp1),
    .cmp2_synced_output_i(cmp2),
    .latch_true_pin_o(tq),
    .latch_true_pin_oe_o(tq_oe),
    .latch_complement_pin_o(cq),
    .latch_complement_pin_oe_o(cq_oe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ceiling well above the longest divider sweep
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      stop_test();
    end
  end

  // Read results are matched against the oldest note
  always @(posedge core_clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("wrong value at %0t: got %h expected no read", $time, dat_r);
      end else begin
        chk(dat_r & msk_q[0], exp_q[0]);
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Classic single cycle, held until ack is sampled; only the global ceiling ends a hung wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {24'h000000, d};
    sel <= 4'hf;
    do begin
      @(posedge core_clk_i);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    wb(1'b0, a, 8'h00);
  endtask

  task automatic ins(input logic [2:0] s);
    @(posedge core_clk_i);
    ext_in <= s[2];
    cmp2 <= s[1];
    cmp1 <= s[0];
  endtask

  // Order of bits: true, true enable, complement, complement enable
  task automatic pins(input logic [3:0] e);
    repeat (4) @(posedge core_clk_i);
    chk({28'h0000000, tq, tq_oe, cq, cq_oe}, {28'h0000000, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, ext_in, cmp1, cmp2} = 6'h00;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h00000000;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    rst_i = 1'b1;
    v = $urandom(81);
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h00000000, 32'hffffffff);
    rd(8'h04, 32'h00000000, 32'hffffffff);
    pins(4'h0);
    v = $urandom;
    wb(1'b1, 8'h04, v[7:0]);
    rd(8'h04, {24'h000000, v[7:0]}, 32'hffffffff);
    // Latch state still unknown, so the latch stays disabled here
    wb(1'b1, 8'h00, {1'b0, v[14:8]});
    rd(8'h00, {24'h000000, 1'b0, v[14:10], 2'h0}, 32'hffffffff);
    wb(1'b1, 8'h04, 8'h00);
    wb(1'b1, 8'h00, 8'h00);
    wb(1'b1, 8'h0c, 8'hff);
    rd(8'h0c, 32'h00000000, 32'hffffffff);
    rd(8'h00, 32'h00000000, 32'hffffffff);
    // Soft pulses, both pins together, reset wins; state known before pins enabled
    wb(1'b1, 8'h00, 8'h82);
    wb(1'b1, 8'h00, 8'h8e);
    pins(4'hd);
    rd(8'h08, 32'h00000001, 32'h00000001);
    wb(1'b1, 8'h00, 8'h8d);
    pins(4'h7);
    wb(1'b1, 8'h00, 8'h8e);
    wb(1'b1, 8'h00, 8'h8f);
    pins(4'h7);
    wb(1'b1, 8'h00, 8'h8e);
    wb(1'b1, 8'h00, 8'h88);
    pins(4'hc);
    wb(1'b1, 8'h00, 8'h84);
    pins(4'h1);
    wb(1'b1, 8'h00, 8'h0c);
    pins(4'h0);
    // Mid-run reset clears the registers but keeps the stored state
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(8'h08, 32'h00000001, 32'h00000001);
    rd(8'h00, 32'h00000000, 32'hffffffff);
    pins(4'h0);
    // Each source: no effect when off, acts when on
    for (int i = 0; i < 8; i++) begin
      init = (i < 4);
      wb(1'b1, 8'h04, 8'h00);
      ins(3'h0);
      wb(1'b1, 8'h00, init ? 8'h8e : 8'h8d);
      ins(3'h7);
      repeat (8) @(posedge core_clk_i);
      rd(8'h08, {31'h0, init}, 32'h00000001);
      wb(1'b1, 8'h04, 8'h01 << i);
      repeat (12) @(posedge core_clk_i);
      rd(8'h08, {31'h0, ~init}, 32'h00000001);
      ins(3'h0);
    end
    // Any one enabled source suffices; pins settle four cycles after the input
    wb(1'b1, 8'h04, 8'hb0);
    wb(1'b1, 8'h00, 8'h8d);
    ins(3'h2);
    repeat (4) @(posedge core_clk_i);
    pins(4'hd);
    rd(8'h08, 32'h00000001, 32'h00000001);
    // Divider period seen as reset pulses against a held set
    wb(1'b1, 8'h04, 8'h84);
    ins(3'h4);
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, 8'h00, {1'b1, c[2:0], 4'h8});
      repeat (2 * (4 << c) + 8) @(posedge core_clk_i);
      while (tq !== 1'b0) begin
        @(posedge core_clk_i);
      end
      n = 0;
      do begin
        @(posedge core_clk_i);
        n++;
      end while (tq !== 1'b0);
      chk(n, 4 << c);
    end
    stop_test();
  end
endmodule // tb_srlc_top
